// ==== hdl/umdf_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module umdf_top
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // classic wishbone slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [3:0]             adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic [31:0]                 dat_o,
    output logic                        ack_o,
    // received frame from serial datapath
    input  wire umdf_pkg::umdf_frame_t  rx_frame,
    // transmitter events and handshake
    input  wire logic                   tx_done,      // frame shifted out, pulse
    input  wire logic                   tx_irq_ack,   // transmit interrupt serviced
    output logic                        tx_load,      // data for transmitter, pulse
    output logic [8:0]                  tx_data,
    output logic [2:0]                  char_size,
    output logic                        two_stop,
    output logic                        rx_complete_flag
);
    // ********************************************************
    // registers
    // ********************************************************
    logic                  filt_r;        // multidrop_filter_enable
    logic                  txc_r;         // tx_complete_flag
    logic [2:0]            size_r;        // char_size_sel
    logic                  stop_r;        // two_stop_sel
    logic                  txn_r;         // tx_ninth_bit
    logic [8:0]            rxd_r;         // receive buffer
    umdf_pkg::umdf_state_t st_r;          // buffer state
    logic                  ack_r;
    logic [31:0]           dat_r;
    logic                  load_r;
    logic [8:0]            txd_r;

    // ********************************************************
    // bus decode
    // ********************************************************
    wire req      = cyc_i & stb_i & ~ack_r;
    wire wr       = req & we_i & sel_i[0];
    wire rd       = req & ~we_i;
    wire wr_a     = wr & (adr_i == umdf_pkg::ADR_CTRL_STATUS_A);
    wire wr_b     = wr & (adr_i == umdf_pkg::ADR_CTRL_B);
    wire wr_c     = wr & (adr_i == umdf_pkg::ADR_CTRL_C);
    wire wr_d     = wr & (adr_i == umdf_pkg::ADR_DATA);
    wire rd_d     = rd & (adr_i == umdf_pkg::ADR_DATA);
    wire full     = (st_r == umdf_pkg::UMDF_FULL);

    // ********************************************************
    // frame classification
    // ********************************************************
    logic is_addr;
    logic accept;
    umdf_classify u_cls
    (
        .filter_en (filt_r),
        .char_size (size_r),
        .frame     (rx_frame),
        .is_addr   (is_addr),
        .accept    (accept)
    );

    // read mux, unmapped reads zero
    wire [7:0] reg_a = {full, txc_r, 5'h00, filt_r};
    wire [7:0] reg_b = {5'h00, size_r[2], rxd_r[8], txn_r};
    wire [7:0] reg_c = {4'h0, stop_r, size_r[1:0], 1'h0};
    wire [31:0] rd_mux =
        (adr_i == umdf_pkg::ADR_CTRL_STATUS_A) ? {24'h000000, reg_a} :
        (adr_i == umdf_pkg::ADR_CTRL_B)        ? {24'h000000, reg_b} :
        (adr_i == umdf_pkg::ADR_CTRL_C)        ? {24'h000000, reg_c} :
        (adr_i == umdf_pkg::ADR_DATA)          ? {24'h000000, rxd_r[7:0]} : 32'h00000000;

    // transmit flag: set beats clear
    wire txc_nxt = tx_done | (txc_r & ~(wr_a & dat_i[umdf_pkg::POS_TXC]) & ~tx_irq_ack);
    // receive state: a new accepted frame wins over a read
    wire st_full_nxt = accept | (full & ~rd_d);

    // ********************************************************
    // bus and control registers
    // ********************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ack_r  <= 1'b0;
            dat_r  <= 32'h00000000;
            filt_r <= umdf_pkg::FILT_RST;
            txc_r  <= 1'b0;
            size_r <= umdf_pkg::SIZE_RST;
            stop_r <= 1'b0;
            txn_r  <= 1'b0;
        end
        else
        begin
            ack_r <= req;
            dat_r <= rd ? rd_mux : 32'h00000000;
            txc_r <= txc_nxt;
            if (wr_a)
                filt_r <= dat_i[umdf_pkg::POS_FILTER_EN];
            if (wr_b)
            begin
                size_r[2] <= dat_i[umdf_pkg::POS_SIZE_HI];
                txn_r     <= dat_i[umdf_pkg::POS_TX_NINTH];
            end
            if (wr_c)
            begin
                size_r[1:0] <= dat_i[umdf_pkg::POS_SIZE_LO +: 2];
                stop_r      <= dat_i[umdf_pkg::POS_TWO_STOP];
            end
        end
    end

    // ********************************************************
    // receive buffer and transmit path
    // ********************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_r   <= umdf_pkg::UMDF_EMPTY;
            rxd_r  <= 9'h000;
            load_r <= 1'b0;
            txd_r  <= 9'h000;
        end
        else
        begin
            st_r   <= st_full_nxt ? umdf_pkg::UMDF_FULL : umdf_pkg::UMDF_EMPTY;
            if (accept)
                rxd_r <= rx_frame.data;
            // transmit takes no account of the filter
            load_r <= wr_d;
            if (wr_d)
                txd_r <= {txn_r, dat_i[7:0]};
        end
    end

    assign dat_o            = dat_r;
    assign ack_o            = ack_r;
    assign tx_load          = load_r;
    assign tx_data          = txd_r;
    assign char_size        = size_r;
    assign two_stop         = stop_r;
    assign rx_complete_flag = full;

    // ********************************************************
    // checks
    // ********************************************************
    data_drop_a: assert property (@(posedge clk) disable iff (!rstn)
        (rx_frame.valid && filt_r && !is_addr && !full) |=> !full)
        else $error("data frame stored while filtering");
    addr_keep_a: assert property (@(posedge clk) disable iff (!rstn)
        (rx_frame.valid && is_addr) |=> (full && rxd_r == $past(rx_frame.data)))
        else $error("address frame not stored");
    nofilt_keep_a: assert property (@(posedge clk) disable iff (!rstn)
        (rx_frame.valid && !filt_r) |=> full)
        else $error("frame lost with filter off");
    nine_type_a: assert property (@(posedge clk) disable iff (!rstn)
        (size_r == umdf_pkg::SIZE_NINE) |-> (is_addr == rx_frame.data[8]))
        else $error("ninth bit not used as type");
    stop_type_a: assert property (@(posedge clk) disable iff (!rstn)
        (size_r != umdf_pkg::SIZE_NINE) |-> (is_addr == rx_frame.stop1))
        else $error("stop bit not used as type");
    txc_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (wr_a && dat_i[umdf_pkg::POS_TXC] && !tx_done) |=> !txc_r)
        else $error("transmit flag not cleared");
    tx_indep_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_d |=> (tx_load && tx_data[7:0] == $past(dat_i[7:0])))
        else $error("transmit load missing");
    size_share_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_c |=> (char_size[1:0] == $past(dat_i[2:1])))
        else $error("size not updated");

    // ********************************************************
    // multi-step checks
    // ********************************************************
    // address frame arriving while the filter is on, no ctrl_status_a write
    sequence addr_filt_s;
        rx_frame.valid && is_addr && filt_r && !wr_a;
    endsequence
    // data offset read with no new frame landing in that cycle
    sequence data_read_s;
        rd_d && !accept;
    endsequence
    // hardware never clears the enable: software decides after the address
    filt_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        addr_filt_s |=> filt_r)
        else $error("filter enable changed by a frame");
    // reading the buffer empties it and drops the receive flag
    read_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        data_read_s |=> !full)
        else $error("receive flag not cleared by read");
    // a finished frame sets the transmit flag even against a clear
    txc_set_a: assert property (@(posedge clk) disable iff (!rstn)
        tx_done |=> txc_r)
        else $error("transmit flag not set");
endmodule
`default_nettype wire

// ==== common/umdf_pkg.sv ====
package umdf_pkg;
    // ********************************************************
    // register map (word offsets, byte addresses)
    // ********************************************************
    localparam logic [3:0] ADR_CTRL_STATUS_A = 4'h0;   // ctrl_status_a
    localparam logic [3:0] ADR_CTRL_B        = 4'h4;   // size high bit, ninth bits
    localparam logic [3:0] ADR_CTRL_C        = 4'h8;   // size low bits, stop select
    localparam logic [3:0] ADR_DATA          = 4'hC;   // data_buffer_port

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int POS_FILTER_EN = 0;  // multidrop_filter_enable in ctrl_status_a
    localparam int POS_TXC       = 6;  // tx_complete_flag
    localparam int POS_RXC       = 7;  // rx_complete_flag
    localparam int POS_TX_NINTH  = 0;  // tx_ninth_bit in ctrl b
    localparam int POS_RX_NINTH  = 1;  // rx_ninth_bit in ctrl b
    localparam int POS_SIZE_HI   = 2;  // char_size_sel bit 2 in ctrl b
    localparam int POS_SIZE_LO   = 1;  // char_size_sel bits 1:0 in ctrl c
    localparam int POS_TWO_STOP  = 3;  // two_stop_sel in ctrl c

    // ********************************************************
    // reset values and codes
    // ********************************************************
    localparam logic [2:0] SIZE_RST  = 3'h3;  // eight data bits
    localparam logic [2:0] SIZE_NINE = 3'h7;  // nine data bits
    localparam logic       FILT_RST  = 1'h0;

    // received frame from the serial datapath
    typedef struct packed {
        logic       valid;     // one-cycle strobe
        logic [8:0] data;      // data bits, bit 8 for nine-bit frames
        logic       stop1;     // first stop bit as sampled
    } umdf_frame_t;

    // receive state
    typedef enum logic [1:0] {
        UMDF_EMPTY = 2'b00,
        UMDF_FULL  = 2'b01
    } umdf_state_t;
endpackage

// ==== hdl/umdf_classify.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********************************************************
// frame type decode
// ********************************************************
module umdf_classify
(
    input  wire logic               filter_en,
    input  wire logic [2:0]         char_size,
    input  wire umdf_pkg::umdf_frame_t frame,
    output logic                    is_addr,
    output logic                    accept
);
    // type bit: ninth bit for nine-bit size, else first stop bit
    wire nine     = (char_size == umdf_pkg::SIZE_NINE);
    wire type_bit = nine ? frame.data[8] : frame.stop1;
    assign is_addr = type_bit;
    // data frames dropped only while filtering
    assign accept  = frame.valid & (~filter_en | type_bit);
endmodule
`default_nettype wire

// ==== testbench/umdf_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********************************************************
// master port model: delivers frames to the filter
// ********************************************************
module umdf_master_model
(
    input  wire logic                   clk,
    output var umdf_pkg::umdf_frame_t   frame
);
    initial frame = '0; // no frame at start
    // one strobed frame, type bit in bit 8 and first stop bit
    task automatic send(input logic [8:0] d, input logic stop1);
        @(posedge clk);
        frame <= '{valid: 1'b1, data: d, stop1: stop1};
        @(posedge clk);
        frame <= '{valid: 1'b0, data: ~d, stop1: ~stop1}; // stale lines flip
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== testbench/umdf_top_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module umdf_top_tb_top;
    logic                  clk, rstn, cyc_i, stb_i, we_i, tx_done, tx_irq_ack;
    logic [3:0]            adr_i, sel_i;
    logic [31:0]           dat_i, dat_o, rd;
    logic                  ack_o, tx_load, two_stop, rx_complete_flag;
    logic [8:0]            tx_data;
    logic [2:0]            char_size;
    umdf_pkg::umdf_frame_t rx_frame;
    int                    err_total, num_checks, cycles, loads;
    // ********************************************************
    // design and far side
    // ********************************************************
    umdf_top i_umdf_top (.clk(clk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .rx_frame(rx_frame), .tx_done(tx_done),
        .tx_irq_ack(tx_irq_ack), .tx_load(tx_load), .tx_data(tx_data),
        .char_size(char_size), .two_stop(two_stop),
        .rx_complete_flag(rx_complete_flag));
    umdf_master_model i_umdf_master_model (.clk(clk), .frame(rx_frame));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // cycle ceiling and transmit load counter
    always @(posedge clk)
    begin
        cycles++;
        if (tx_load === 1'b1) loads++;
        if (cycles == 4000)
        begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // classic wishbone cycle, held until ack is sampled
    task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
        // wait for the answer; only the cycle ceiling ends a hang
        do
        begin
            @(posedge clk);
        end
        while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'h0;
    endtask
    task automatic rdchk(string what, logic [3:0] a, logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    task automatic frm(logic [8:0] d, logic s, logic exp);
        i_umdf_master_model.send(d, s);
        chk("rxc", {31'h0, rx_complete_flag}, {31'h0, exp});
    endtask
    task automatic pulse(logic which);
        @(posedge clk);
        if (which) tx_done <= 1'b1; else tx_irq_ack <= 1'b1;
        @(posedge clk);
        {tx_done, tx_irq_ack} <= 2'h0;
    endtask
    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset();
        rdchk("ctrl_a", umdf_pkg::ADR_CTRL_STATUS_A, 32'h0);
        rdchk("ctrl_c", umdf_pkg::ADR_CTRL_C, 32'h6);
        rdchk("unmapped", 4'h2, 32'h0);
        chk("size", {29'h0, char_size}, 32'h3);
    endtask
    task automatic t_nine();
        wb(1'b1, umdf_pkg::ADR_CTRL_B, 32'h4);
        wb(1'b1, umdf_pkg::ADR_CTRL_C, 32'h6);
        chk("size", {29'h0, char_size}, 32'h7);
        wb(1'b1, umdf_pkg::ADR_CTRL_STATUS_A, 32'h1);
        frm(9'h0AA, 1'b1, 1'b0);
        frm(9'h155, 1'b0, 1'b1);
        rdchk("ninth", umdf_pkg::ADR_CTRL_B, 32'h6);
        rdchk("addr", umdf_pkg::ADR_DATA, 32'h55);
        frm(9'h033, 1'b1, 1'b0);
        wb(1'b1, umdf_pkg::ADR_CTRL_STATUS_A, 32'h0);
        frm(9'h033, 1'b0, 1'b1);
        rdchk("data", umdf_pkg::ADR_DATA, 32'h33);
    endtask
    task automatic t_eight();
        wb(1'b1, umdf_pkg::ADR_CTRL_B, 32'h0);
        wb(1'b1, umdf_pkg::ADR_CTRL_C, 32'hE);
        chk("stop", {28'h0, two_stop, char_size}, 32'hB);
        wb(1'b1, umdf_pkg::ADR_CTRL_STATUS_A, 32'h1);
        frm(9'h1F0, 1'b0, 1'b0);
        frm(9'h00F, 1'b1, 1'b1);
        rdchk("addr8", umdf_pkg::ADR_DATA, 32'h0F);
    endtask
    task automatic t_tx();
        wb(1'b1, umdf_pkg::ADR_CTRL_B, 32'h1);
        wb(1'b1, umdf_pkg::ADR_DATA, 32'hA5);
        @(posedge clk);
        chk("loads", loads, 32'h1);
        chk("txdata", {23'h0, tx_data}, 32'h1A5);
        // same load with the filter off: transmit must not change
        wb(1'b1, umdf_pkg::ADR_CTRL_STATUS_A, 32'h0);
        wb(1'b1, umdf_pkg::ADR_DATA, 32'h5A);
        @(posedge clk);
        chk("loads_nofilt", loads, 32'h2);
        chk("txdata_nofilt", {23'h0, tx_data}, 32'h15A);
        wb(1'b1, umdf_pkg::ADR_CTRL_STATUS_A, 32'h1);
    endtask
    task automatic t_txc();
        pulse(1'b1);
        rdchk("txc_set", umdf_pkg::ADR_CTRL_STATUS_A, 32'h41);
        wb(1'b1, umdf_pkg::ADR_CTRL_STATUS_A, 32'h41);
        rdchk("txc_w1c", umdf_pkg::ADR_CTRL_STATUS_A, 32'h1);
        pulse(1'b1);
        pulse(1'b0);
        rdchk("txc_irq", umdf_pkg::ADR_CTRL_STATUS_A, 32'h1);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        {rstn, cyc_i, stb_i, we_i, tx_done, tx_irq_ack} = 6'h0;
        {adr_i, dat_i, sel_i} = {4'h0, 32'h0, 4'hF};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_nine();
        t_eight();
        t_tx();
        t_txc();
        summarize();
    end
endmodule
`default_nettype wire
